/* design/coe_pkg.sv */
// Constants shared by the channel-two output expand and overload block
package coe_pkg;
	// Register byte offsets
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_EXPAND = 12'h004;
	localparam logic [11:0] OFS_FLAGS = 12'h008;
	localparam logic [11:0] OFS_INT_STAT = 12'h00C;
	localparam logic [11:0] OFS_INT_MASK = 12'h010;
	// Control register fields
	localparam int CTRL_OUT_SEL_BIT = 0;
	localparam int CTRL_RATIO_EN_BIT = 1;
	localparam int CTRL_QSEL_LSB = 2;
	localparam int QSEL_W = 2;
	localparam int EXP_W = 2;
	localparam int NUM_QTY = 4;
	// Output select codes
	localparam logic OUT_SEL_DISPLAY = 1'b0;
	localparam logic OUT_SEL_Y = 1'b1;
	// Quantity code that stands for Y
	localparam logic [1:0] QTY_Y = 2'h0;
	// Expand codes; the spare code acts as x1
	localparam logic [1:0] EXP_X1 = 2'h0;
	localparam logic [1:0] EXP_X10 = 2'h1;
	localparam logic [1:0] EXP_X100 = 2'h2;
	// Extra display digits per expand
	localparam logic [1:0] DIGITS_X1 = 2'h0;
	localparam logic [1:0] DIGITS_X10 = 2'h1;
	localparam logic [1:0] DIGITS_X100 = 2'h2;
	// Flag and interrupt bit positions
	localparam int FLG_RATIO_HIGH = 0;
	localparam int FLG_RATIO_LOW = 1;
	localparam int FLG_AOUT_OVL = 2;
	localparam int FLG_DISP_OVL = 3;
	localparam int NUM_FLG = 4;
	// Ratio input thresholds in millivolts
	localparam int RATIO_HIGH_MV = 10500;
	localparam int RATIO_LOW_MV = 50;
	localparam int RATIO_UNITY_MV = 1000;
	// Overload limits in percent of full scale
	localparam int AOUT_LIMIT_PCT = 105;
	localparam int DISP_LIMIT_PCT = 110;
	// Reset values
	localparam logic [3:0] CTRL_RST = 4'h0;
	localparam logic [7:0] EXPAND_RST = 8'h00;
	localparam logic [3:0] INT_MASK_RST = 4'h0;
endpackage

/* design/coe_ch2_output.sv */
// Channel-two output expand, routing and overload flags with APB registers
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ps
module coe_ch2_output #(
	parameter int DW = 24,
	parameter int RW = 16,
	parameter int FS = 1048576
) (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic sample_valid_i,
	input wire logic signed [DW-1:0] disp_val_i,
	input wire logic signed [DW-1:0] y_val_i,
	input wire logic signed [RW-1:0] ratio_in_i,
	output logic signed [DW+7:0] aout_o,
	output logic aout_valid_o,
	output logic signed [DW-1:0] disp_val_o,
	output logic [1:0] disp_digits_o,
	output logic ind_x10_o,
	output logic ind_x100_o,
	output logic ind_expanded_o,
	output logic ratio_high_o,
	output logic ratio_low_o,
	output logic ratioed_valid_o,
	output logic aout_overload_flag_o,
	output logic disp_overload_flag_o,
	output logic signed [RW-1:0] ratio_divisor_o,
	output logic irq_o
);
	localparam int AW = DW + 8;
	localparam logic [AW-1:0] AOUT_LIM = AW'(FS / 100 * coe_pkg::AOUT_LIMIT_PCT);
	localparam logic [AW-1:0] DISP_LIM = AW'(FS / 100 * coe_pkg::DISP_LIMIT_PCT);
	localparam logic [AW-1:0] R_HI = AW'(coe_pkg::RATIO_HIGH_MV);
	localparam logic [AW-1:0] R_LO = AW'(coe_pkg::RATIO_LOW_MV);
	localparam logic [RW-1:0] R_UNITY = RW'(coe_pkg::RATIO_UNITY_MV);

	typedef struct packed {
		logic out_sel;
		logic ratio_en;
		logic [1:0] qsel;
		logic [7:0] exp_tab;
		logic [3:0] int_stat;
		logic [3:0] int_mask;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic signed [AW-1:0] aout;
		logic aout_valid;
		logic signed [DW-1:0] disp;
		logic [1:0] digits;
		logic x10;
		logic x100;
		logic expd;
		logic [3:0] flags;
		logic rvalid;
		logic signed [RW-1:0] div;
		logic irq;
	} coe_state_t;

	coe_state_t s_r;
	coe_state_t s_nxt;

	// Multiply by the expand factor with shifts and adds
	function automatic logic signed [AW-1:0] expand_f(
		input logic signed [DW-1:0] v,
		input logic [1:0] code
	);
		logic signed [AW-1:0] w;
		w = AW'(v);
		case (code)
			coe_pkg::EXP_X10: expand_f = (w <<< 3) + (w <<< 1);
			coe_pkg::EXP_X100: expand_f = (w <<< 6) + (w <<< 5) + (w <<< 2);
			default: expand_f = w;
		endcase
	endfunction

	// Magnitude as an unsigned value, safe for the most negative code
	function automatic logic [AW-1:0] mag_f(input logic signed [AW-1:0] v);
		mag_f = v[AW-1] ? AW'(-v) : AW'(v);
	endfunction

	logic [1:0] disp_exp;
	logic [1:0] y_exp;
	logic signed [AW-1:0] disp_x;
	logic signed [AW-1:0] y_x;
	logic signed [AW-1:0] aout_calc;
	logic [AW-1:0] ratio_mag;
	logic [3:0] flag_calc;
	logic acc_done;
	logic wr_en;

	// Per-quantity expand lookup; Y always reads its own slot
	assign disp_exp =
		s_r.exp_tab[s_r.qsel*coe_pkg::EXP_W +: coe_pkg::EXP_W];
	assign y_exp =
		s_r.exp_tab[coe_pkg::QTY_Y*coe_pkg::EXP_W +: coe_pkg::EXP_W];
	// Expanded copies only; the incoming values stay untouched
	assign disp_x = expand_f(disp_val_i, disp_exp);
	assign y_x = expand_f(y_val_i, y_exp);
	// Analog routing per output select
	assign aout_calc = (s_r.out_sel == coe_pkg::OUT_SEL_Y) ?
		y_x : disp_x;
	assign ratio_mag = mag_f(AW'(ratio_in_i));
	// Live condition of every flag for the present sample
	assign flag_calc[coe_pkg::FLG_RATIO_HIGH] = ratio_mag > R_HI;
	assign flag_calc[coe_pkg::FLG_RATIO_LOW] = ratio_mag < R_LO;
	assign flag_calc[coe_pkg::FLG_AOUT_OVL] = mag_f(aout_calc) > AOUT_LIM;
	assign flag_calc[coe_pkg::FLG_DISP_OVL] = mag_f(disp_x) > DISP_LIM;
	// APB access completes in the cycle pready is high
	assign acc_done = psel_i && penable_i && s_r.pready;
	assign wr_en = acc_done && pwrite_i && !s_r.pslverr;

	// Next-state logic for bus, registers and output datapath
	always_comb begin
		logic [3:0] w1c;
		logic [3:0] ev;
		logic hit;
		w1c = 4'h0;
		ev = 4'h0;
		hit = 1'b0;
		s_nxt = s_r;
		s_nxt.aout_valid = 1'b0;
		// Slave answers one cycle into the access phase
		s_nxt.pready = psel_i && penable_i && !s_r.pready;
		if (psel_i && penable_i && !s_r.pready) begin
			hit = 1'b1;
			s_nxt.prdata = 32'h0000_0000;
			if (paddr_i == coe_pkg::OFS_CTRL) begin
				s_nxt.prdata[3:0] = {s_r.qsel, s_r.ratio_en, s_r.out_sel};
			end else if (paddr_i == coe_pkg::OFS_EXPAND) begin
				s_nxt.prdata[7:0] = s_r.exp_tab;
			end else if (paddr_i == coe_pkg::OFS_FLAGS) begin
				s_nxt.prdata[3:0] = s_r.flags;
			end else if (paddr_i == coe_pkg::OFS_INT_STAT) begin
				s_nxt.prdata[3:0] = s_r.int_stat;
			end else if (paddr_i == coe_pkg::OFS_INT_MASK) begin
				s_nxt.prdata[3:0] = s_r.int_mask;
			end else begin
				hit = 1'b0;
			end
			s_nxt.pslverr = !hit;
		end else if (!(psel_i && penable_i)) begin
			s_nxt.pslverr = 1'b0;
		end
		// Register writes take effect on the completing edge
		if (wr_en) begin
			if (paddr_i == coe_pkg::OFS_CTRL) begin
				s_nxt.out_sel = pwdata_i[coe_pkg::CTRL_OUT_SEL_BIT];
				s_nxt.ratio_en = pwdata_i[coe_pkg::CTRL_RATIO_EN_BIT];
				s_nxt.qsel = pwdata_i[coe_pkg::CTRL_QSEL_LSB +: coe_pkg::QSEL_W];
			end else if (paddr_i == coe_pkg::OFS_EXPAND) begin
				s_nxt.exp_tab = pwdata_i[7:0];
			end else if (paddr_i == coe_pkg::OFS_INT_STAT) begin
				w1c = pwdata_i[3:0];
			end else if (paddr_i == coe_pkg::OFS_INT_MASK) begin
				s_nxt.int_mask = pwdata_i[3:0];
			end
		end
		// Indicators follow the displayed quantity's expand only
		s_nxt.x10 = disp_exp == coe_pkg::EXP_X10;
		s_nxt.x100 = disp_exp == coe_pkg::EXP_X100;
		s_nxt.expd = s_nxt.x10 || s_nxt.x100;
		if (s_nxt.x100) begin
			s_nxt.digits = coe_pkg::DIGITS_X100;
		end else if (s_nxt.x10) begin
			s_nxt.digits = coe_pkg::DIGITS_X10;
		end else begin
			s_nxt.digits = coe_pkg::DIGITS_X1;
		end
		// Divisor handed upstream; unity when ratio is off
		s_nxt.div = s_r.ratio_en ? ratio_in_i : R_UNITY;
		// Each sample refreshes the outputs and every flag
		if (sample_valid_i) begin
			s_nxt.aout = aout_calc;
			s_nxt.aout_valid = 1'b1;
			s_nxt.disp = disp_val_i;
			s_nxt.flags = flag_calc;
			s_nxt.rvalid = !(s_r.ratio_en &&
				flag_calc[coe_pkg::FLG_RATIO_HIGH]);
			ev = flag_calc;
		end
		// Sticky status: a new event beats a same-cycle clear
		s_nxt.int_stat = (s_r.int_stat & ~w1c) | ev;
		s_nxt.irq = |(s_nxt.int_stat & s_nxt.int_mask);
	end

	// State register
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			s_r <= '0;
			s_r.exp_tab <= coe_pkg::EXPAND_RST;
			s_r.int_mask <= coe_pkg::INT_MASK_RST;
			s_r.rvalid <= 1'b1;
			s_r.div <= R_UNITY;
			{s_r.qsel, s_r.ratio_en, s_r.out_sel} <= coe_pkg::CTRL_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from the state register
	assign prdata_o = s_r.prdata;
	assign pready_o = s_r.pready;
	assign pslverr_o = s_r.pslverr;
	assign aout_o = s_r.aout;
	assign aout_valid_o = s_r.aout_valid;
	assign disp_val_o = s_r.disp;
	assign disp_digits_o = s_r.digits;
	assign ind_x10_o = s_r.x10;
	assign ind_x100_o = s_r.x100;
	assign ind_expanded_o = s_r.expd;
	assign ratio_high_o = s_r.flags[coe_pkg::FLG_RATIO_HIGH];
	assign ratio_low_o = s_r.flags[coe_pkg::FLG_RATIO_LOW];
	assign ratioed_valid_o = s_r.rvalid;
	assign aout_overload_flag_o = s_r.flags[coe_pkg::FLG_AOUT_OVL];
	assign disp_overload_flag_o = s_r.flags[coe_pkg::FLG_DISP_OVL];
	assign ratio_divisor_o = s_r.div;
	assign irq_o = s_r.irq;

	// Checks on the datapath and flags
	sequence s_sample;
		sample_valid_i;
	endsequence

	property p_ratio_hi;
		@(posedge clk_sys_i) disable iff (srst_i)
		s_sample ##0 (ratio_mag > R_HI) |=> ratio_high_o && !ratio_low_o;
	endproperty
	a_ratio_hi: assert property (p_ratio_hi) else $error("ratio high missed");

	property p_ratio_lo;
		@(posedge clk_sys_i) disable iff (srst_i)
		s_sample ##0 (ratio_mag < R_LO) |=> ratio_low_o;
	endproperty
	a_ratio_lo: assert property (p_ratio_lo) else $error("ratio low missed");

	property p_ind;
		@(posedge clk_sys_i) disable iff (srst_i)
		##1 (ind_x10_o + ind_x100_o <= 1) && (ind_expanded_o == (ind_x10_o || ind_x100_o))
			&& (ind_x10_o == ($past(disp_exp) == coe_pkg::EXP_X10));
	endproperty
	a_ind: assert property (p_ind) else $error("expand indicators wrong");

	property p_gain;
		@(posedge clk_sys_i) disable iff (srst_i)
		s_sample ##0 (s_r.out_sel == coe_pkg::OUT_SEL_Y)
			##0 (y_exp == coe_pkg::EXP_X100)
			|=> aout_valid_o && (aout_o == AW'($past(y_val_i)) * 100);
	endproperty
	a_gain: assert property (p_gain) else $error("analog gain wrong");

	property p_route;
		@(posedge clk_sys_i) disable iff (srst_i)
		s_sample ##0 (s_r.out_sel == coe_pkg::OUT_SEL_DISPLAY)
			##0 (disp_exp == coe_pkg::EXP_X1)
			|=> (aout_o == AW'(disp_val_o));
	endproperty
	a_route: assert property (p_route) else $error("display route wrong");

	property p_aovl;
		@(posedge clk_sys_i) disable iff (srst_i)
		s_sample |=> aout_overload_flag_o == (mag_f(aout_o) > AOUT_LIM);
	endproperty
	a_aovl: assert property (p_aovl) else $error("analog overload wrong");

	property p_dovl;
		@(posedge clk_sys_i) disable iff (srst_i)
		s_sample ##0 (disp_exp == coe_pkg::EXP_X1)
			|=> disp_overload_flag_o == (mag_f(AW'(disp_val_o)) > DISP_LIM);
	endproperty
	a_dovl: assert property (p_dovl) else $error("display overload wrong");

	property p_hold;
		@(posedge clk_sys_i) disable iff (srst_i)
		!sample_valid_i |=> $stable(s_r.flags) && !aout_valid_o;
	endproperty
	a_hold: assert property (p_hold) else $error("flags moved");

	property p_div;
		@(posedge clk_sys_i) disable iff (srst_i)
		!s_r.ratio_en |=> ratio_divisor_o == R_UNITY;
	endproperty
	a_div: assert property (p_div) else $error("divisor not unity");

	property p_sticky;
		@(posedge clk_sys_i) disable iff (srst_i)
		s_sample ##0 flag_calc[coe_pkg::FLG_DISP_OVL]
			|=> s_r.int_stat[coe_pkg::FLG_DISP_OVL]
			&& (irq_o || !s_r.int_mask[coe_pkg::FLG_DISP_OVL]);
	endproperty
	a_sticky: assert property (p_sticky) else $error("event not kept");
endmodule

/* tb/coe_sink_model.sv */
// Behavioural analog converter and display that capture each output sample
`timescale 1ns/1ps
module coe_sink_model (
	input wire logic clk_sys_i,
	input wire logic aout_valid_i,
	input wire logic [31:0] aout_i,
	input wire logic [23:0] disp_i,
	output logic [31:0] aout_last_o,
	output logic [23:0] disp_last_o
);
	// Latch converter code and display value on each valid pulse
	always_ff @(posedge clk_sys_i) begin
		if (aout_valid_i) begin
			aout_last_o <= aout_i;
			disp_last_o <= disp_i;
		end
	end
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the channel-two output block
`timescale 1ns/1ps
module tb_top;
	logic clk_sys_i = 1'b0;
	logic srst_i = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready, pslverr, aout_v, ix10, ix100, iexp, rhi, rlo, rval;
	logic aovl, dovl, irq;
	logic svalid = 1'b0;
	logic signed [23:0] disp_in = 24'h000000;
	logic signed [23:0] y_in = 24'h000000;
	logic signed [15:0] ratio_in = 16'h03E8;
	logic signed [31:0] aout;
	logic signed [23:0] disp_out;
	logic signed [15:0] rdiv;
	logic [1:0] digits;
	logic [31:0] aout_last;
	logic [23:0] disp_last;
	int n_fail = 0;
	int comparisons = 0;
	// Clock at 40 MHz
	always #12.5 clk_sys_i = ~clk_sys_i;
	coe_ch2_output dut_u (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .sample_valid_i(svalid),
		.disp_val_i(disp_in), .y_val_i(y_in), .ratio_in_i(ratio_in),
		.aout_o(aout), .aout_valid_o(aout_v), .disp_val_o(disp_out),
		.disp_digits_o(digits), .ind_x10_o(ix10), .ind_x100_o(ix100),
		.ind_expanded_o(iexp), .ratio_high_o(rhi), .ratio_low_o(rlo),
		.ratioed_valid_o(rval), .aout_overload_flag_o(aovl),
		.disp_overload_flag_o(dovl), .ratio_divisor_o(rdiv), .irq_o(irq));
	coe_sink_model sink_u (.clk_sys_i(clk_sys_i), .aout_valid_i(aout_v),
		.aout_i(aout), .disp_i(disp_out), .aout_last_o(aout_last),
		.disp_last_o(disp_last));
	// Compare and count
	task automatic check(input string nm, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One APB transfer; holds the request until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge clk_sys_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys_i);
		penable <= 1'b1;
		// Sample pready, data and error at the completing edge itself
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) n_fail++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x,
		input logic xe);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h00000000, r, e);
		check("prdata", r, x);
		check("pslverr", {31'h0, e}, {31'h0, xe});
	endtask
	// One sample pulse, returns once its results have landed
	task automatic smp(input logic [23:0] d, y, input logic [15:0] r);
		@(posedge clk_sys_i);
		svalid <= 1'b1;
		disp_in <= d;
		y_in <= y;
		ratio_in <= r;
		@(posedge clk_sys_i);
		svalid <= 1'b0;
		// The sink latches on the valid pulse one edge later
		@(posedge clk_sys_i);
		#1;
	endtask
	task automatic settle();
		repeat (2) @(posedge clk_sys_i);
		#1;
	endtask
	// Reset values and an unmapped access
	task automatic t_reset();
		check("rval", {31'h0, rval}, 32'h1);
		check("rdiv", 32'(rdiv), 32'h000003E8);
		rd(coe_pkg::OFS_CTRL, 32'h0, 1'b0);
		rd(coe_pkg::OFS_EXPAND, 32'h0, 1'b0);
		rd(coe_pkg::OFS_INT_MASK, 32'h0, 1'b0);
		rd(12'h014, 32'h0, 1'b1);
	endtask
	// Expand codes x1, x10 and x100 on the displayed Y quantity
	task automatic t_expand();
		int m;
		for (int k = 0; k < 3; k++) begin
			m = (k == 0) ? 1 : (k == 1) ? 10 : 100;
			wr(coe_pkg::OFS_EXPAND, 32'(k));
			smp(24'h000100, 24'h000007, 16'h03E8);
			check("aout", aout_last, 32'(256 * m));
			check("disp", 32'(disp_last), 32'h100);
			check("digits", 32'(digits), 32'(k));
			check("x10", {31'h0, ix10}, 32'(k == 1));
			check("x100", {31'h0, ix100}, 32'(k == 2));
			check("expd", {31'h0, iexp}, 32'(k != 0));
		end
	endtask
	// Y routing with a different expand on the displayed quantity
	task automatic t_route();
		wr(coe_pkg::OFS_CTRL, 32'h5);
		wr(coe_pkg::OFS_EXPAND, 32'h9);
		smp(24'h000100, 24'h000007, 16'h03E8);
		check("aout_y", aout_last, 32'h46);
		check("x100", {31'h0, ix100}, 32'h1);
		check("x10", {31'h0, ix10}, 32'h0);
		wr(coe_pkg::OFS_CTRL, 32'h4);
		smp(24'h000100, 24'h000007, 16'h03E8);
		check("aout_d", aout_last, 32'h6400);
		wr(coe_pkg::OFS_CTRL, 32'h1);
		wr(coe_pkg::OFS_EXPAND, 32'h2);
		smp(24'h000100, 24'hFFFFF9, 16'h03E8);
		check("aout_y100", aout_last, 32'hFFFFFD44);
	endtask
	// Ratio input range flags around both thresholds
	task automatic t_ratio();
		logic [15:0] rv [6] = '{16'h2905, 16'h2904, 16'hD6FB, 16'h0031,
			16'h0032, 16'hFFCF};
		logic [1:0] hl [6] = '{2'h2, 2'h0, 2'h2, 2'h1, 2'h0, 2'h1};
		wr(coe_pkg::OFS_CTRL, 32'h2);
		for (int i = 0; i < 6; i++) begin
			smp(24'h000010, 24'h000010, rv[i]);
			check("hi", {31'h0, rhi}, 32'(hl[i][1]));
			check("lo", {31'h0, rlo}, 32'(hl[i][0]));
			check("rval", {31'h0, rval}, 32'(!hl[i][1]));
		end
		smp(24'h000010, 24'h000010, 16'h07D0);
		check("rdiv", 32'(rdiv), 32'h000007D0);
	endtask
	// Overload limits at x10 on display routing, then the interrupt
	task automatic t_ovl();
		logic [23:0] dv [6] = '{24'h01AE0C, 24'h01AE0D, 24'h01C287,
			24'h01C288, 24'hFE3D78, 24'h000010};
		logic [1:0] ad [6] = '{2'h0, 2'h2, 2'h2, 2'h3, 2'h3, 2'h0};
		wr(coe_pkg::OFS_CTRL, 32'h0);
		wr(coe_pkg::OFS_EXPAND, 32'h1);
		for (int i = 0; i < 6; i++) begin
			smp(dv[i], 24'h000010, 16'h03E8);
			check("aovl", {31'h0, aovl}, 32'(ad[i][1]));
			check("dovl", {31'h0, dovl}, 32'(ad[i][0]));
		end
		wr(coe_pkg::OFS_INT_STAT, 32'hF);
		wr(coe_pkg::OFS_INT_MASK, 32'h8);
		settle();
		check("irq", {31'h0, irq}, 32'h0);
		smp(24'hFE3D78, 24'h000010, 16'h03E8);
		rd(coe_pkg::OFS_FLAGS, 32'hC, 1'b0);
		settle();
		check("irq", {31'h0, irq}, 32'h1);
		smp(24'h000010, 24'h000010, 16'h03E8);
		wr(coe_pkg::OFS_INT_MASK, 32'h0);
		settle();
		check("irq", {31'h0, irq}, 32'h0);
		wr(coe_pkg::OFS_INT_MASK, 32'h8);
		wr(coe_pkg::OFS_INT_STAT, 32'h8);
		settle();
		check("irq", {31'h0, irq}, 32'h0);
		rd(coe_pkg::OFS_INT_STAT, 32'h4, 1'b0);
	endtask
	// Verdict and end of run
	task automatic end_sim();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Watchdog against a hung handshake
	initial begin
		#100000;
		n_fail++;
		end_sim();
	end
	// Main sequence
	initial begin
		repeat (2) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		#1;
		t_reset();
		t_expand();
		t_route();
		t_ratio();
		t_ovl();
		end_sim();
	end
endmodule
